// ==== hdl/bdes_cfg.svh ====
// Constants for the block-device error and status checker.
`ifndef BDES_CFG_SVH
`define BDES_CFG_SVH
`define BDES_STAT_GOOD 8'h00
`define BDES_STAT_CHECK 8'h02
`define BDES_KEY_NO_SENSE 4'h0
`define BDES_KEY_RECOVERED 4'h1
`define BDES_KEY_MEDIUM 4'h3
`define BDES_KEY_HARDWARE 4'h4
`define BDES_KEY_ILLEGAL 4'h5
`define BDES_KEY_UNIT_ATTN 4'h6
`define BDES_KEY_PROTECT 4'h7
`define BDES_KEY_BLANK 4'h8
`define BDES_KEY_ABORTED 4'hb
`define BDES_ASC_NONE 8'h00
`define BDES_ASC_LBA_RANGE 8'h21
`define BDES_ASC_INV_FIELD 8'h24
`define BDES_ASC_RESET 8'h29
`define BDES_ASC_MEDIUM_CHG 8'h28
`define BDES_ASC_DIAG_FAIL 8'h40
`define BDES_ASC_UNRECOV 8'h11
`define BDES_ASC_RECOV 8'h17
`define BDES_ASC_OVERRUN 8'h4b
`define BDES_ASC_WPROT 8'h27
`define BDES_ASC_BLANK 8'h14
`define BDES_ASC_NOT_BLANK 8'h00
`endif

// ==== hdl/bdes_core.sv ====
// Command error checker: limit checks, sense key selection and one sense hold shared by all initiators.
`timescale 1ns/100ps
`include "bdes_cfg.svh"
module bdes_core
  import bdes_pkg::*;
#(
  parameter int NUM_INIT = 8,
  parameter logic [31:0] LAST_LBA = 32'h000f_ffff
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Media conditions, asynchronous to this clock.
  input wire logic wprot_i,
  input wire logic worm_i,
  input wire logic blank_chk_i,
  input wire logic medium_chg_i,
  // Command issue from the command decoder.
  input wire logic cmd_valid_i,
  input wire bdes_cmd_t cmd_i,
  // Faults raised by the data path while the command runs.
  input wire logic fault_valid_i,
  input wire bdes_fault_t fault_i,
  input wire logic xfer_end_i,
  // Command completion.
  output bdes_result_t result_o,
  output logic done_o,
  output logic busy_o,
  output logic xfer_allow_o,
  output logic [31:0] xfer_stop_lba_o,
  output logic [NUM_INIT-1:0] attn_o
);

  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic mchg_d;
  logic [NUM_INIT-1:0] attn;
  logic [NUM_INIT-1:0] next_attn;
  logic [NUM_INIT-1:0] lim_ok;
  logic [NUM_INIT-1:0] next_lim_ok;
  logic [31:0] lim_lo [NUM_INIT];
  logic [31:0] lim_hi [NUM_INIT];
  logic [31:0] next_lim_lo [NUM_INIT];
  logic [31:0] next_lim_hi [NUM_INIT];
  logic busy;
  logic next_busy;
  bdes_state_t state;
  bdes_state_t next_state;
  bdes_cmd_t cmd;
  bdes_cmd_t next_cmd;
  logic found;
  logic next_found;
  bdes_result_t res;
  bdes_result_t next_res;
  logic done;
  logic next_done;
  logic allow;
  logic next_allow;
  logic [31:0] stop_lba;
  logic [31:0] next_stop_lba;
  logic [32:0] last_blk;
  logic [2:0] id;

  // Pin-level media conditions pass two flops; only sync_b is read.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
      mchg_d <= 1'b0;
    end else begin
      sync_a <= {worm_i, medium_chg_i, blank_chk_i, wprot_i};
      sync_b <= sync_a;
      mchg_d <= sync_b[2];
    end
  end

  assign id = cmd_i.init_id;
  assign last_blk = {1'b0, cmd_i.lba} + {17'h0, cmd_i.nblocks} - 33'h1;

  // Precheck at command start, first detected condition wins.
  always_comb begin
    next_state = state;
    next_cmd = cmd;
    next_found = found;
    next_res = res;
    next_done = 1'b0;
    next_allow = allow;
    next_stop_lba = stop_lba;
    next_attn = attn;
    next_lim_ok = lim_ok;
    next_lim_lo = lim_lo;
    next_lim_hi = lim_hi;
    unique case (state)
      BDES_IDLE: begin
        if (cmd_valid_i) begin
          next_cmd = cmd_i;
          next_found = 1'b1;
          next_allow = 1'b0;
          next_stop_lba = cmd_i.lba;
          next_state = BDES_DONE;
          // a new command from any initiator replaces the held sense.
          next_res = '{`BDES_STAT_CHECK, `BDES_KEY_NO_SENSE, `BDES_ASC_NONE, 1'b0, 32'h0, id};
          if (attn[id]) begin
            next_attn[id] = 1'b0;
            next_res.key = `BDES_KEY_UNIT_ATTN;
            next_res.asc = `BDES_ASC_RESET;
          end else if (cmd_i.relative && !cmd_i.linked) begin
            next_res.key = `BDES_KEY_ILLEGAL;
            next_res.asc = `BDES_ASC_INV_FIELD;
          end else if (cmd_i.opt_unsupported) begin
            next_res.key = `BDES_KEY_ILLEGAL;
            next_res.asc = `BDES_ASC_INV_FIELD;
          end else if (cmd_i.lba > LAST_LBA) begin
            next_res.key = `BDES_KEY_ILLEGAL;
            next_res.asc = `BDES_ASC_LBA_RANGE;
            next_res.info_valid = 1'b1;
            next_res.info = cmd_i.lba;
          end else if (last_blk > {1'b0, LAST_LBA}) begin
            next_res.key = `BDES_KEY_ILLEGAL;
            next_res.asc = `BDES_ASC_LBA_RANGE;
            next_res.info_valid = 1'b1;
            next_res.info = LAST_LBA + 32'h1;
          end else if (cmd_i.relative && lim_ok[id] &&
                       (cmd_i.lba < lim_lo[id] || last_blk > {1'b0, lim_hi[id]})) begin
            next_res.key = `BDES_KEY_ILLEGAL;
            next_res.asc = `BDES_ASC_LBA_RANGE;
            next_res.info_valid = 1'b1;
            next_res.info = (cmd_i.lba < lim_lo[id]) ? cmd_i.lba : lim_hi[id] + 32'h1;
          end else if (cmd_i.is_write && sync_b[0]) begin
            next_res.key = `BDES_KEY_PROTECT;
            next_res.asc = `BDES_ASC_WPROT;
          end else if (cmd_i.is_set_limits) begin
            next_lim_ok[id] = 1'b1;
            next_lim_lo[id] = cmd_i.lim_lo;
            next_lim_hi[id] = cmd_i.lim_hi;
            next_res.status = `BDES_STAT_GOOD;
            next_found = 1'b0;
          end else begin
            next_found = 1'b0;
            next_allow = 1'b1;
            next_res.status = `BDES_STAT_GOOD;
            next_stop_lba = last_blk[31:0] + 32'h1;
            next_state = BDES_EXEC;
          end
          // An unlinked command other than a set-limits one closes the chain, so its limits go.
          if (!cmd_i.linked && !cmd_i.is_set_limits) begin
            next_lim_ok[id] = 1'b0;
          end
        end
      end
      BDES_EXEC: begin
        if (fault_valid_i && !found) begin
          next_found = 1'b1;
          next_res.status = `BDES_STAT_CHECK;
          if (fault_i.diag_fail) begin
            next_res.key = `BDES_KEY_HARDWARE;
            next_res.asc = `BDES_ASC_DIAG_FAIL;
          end else if (fault_i.unrecov_med || fault_i.unrecov_hw) begin
            next_res.key = fault_i.unrecov_med ? `BDES_KEY_MEDIUM : `BDES_KEY_HARDWARE;
            next_res.asc = `BDES_ASC_UNRECOV;
            next_allow = 1'b0;
          end else if (fault_i.overrun) begin
            next_res.key = `BDES_KEY_ABORTED;
            next_res.asc = `BDES_ASC_OVERRUN;
            next_allow = 1'b0;
          end else if (sync_b[3] && fault_i.blank_hit && !cmd.is_write) begin
            next_res.key = `BDES_KEY_BLANK;
            next_res.asc = `BDES_ASC_BLANK;
            next_res.info_valid = 1'b1;
            next_res.info = fault_i.event_lba;
            next_stop_lba = fault_i.event_lba;
          end else if (sync_b[3] && sync_b[1] && fault_i.written_hit && cmd.is_write) begin
            next_res.key = `BDES_KEY_BLANK;
            next_res.asc = `BDES_ASC_NOT_BLANK;
            next_res.info_valid = 1'b1;
            next_res.info = fault_i.event_lba;
            next_allow = 1'b0;
          end else if (fault_i.recovered) begin
            next_res.key = `BDES_KEY_RECOVERED;
            next_res.asc = `BDES_ASC_RECOV;
          end else begin
            next_found = 1'b0;
            next_res.status = `BDES_STAT_GOOD;
          end
        end
        if (xfer_end_i) begin
          next_allow = 1'b0;
          next_state = BDES_DONE;
        end
      end
      BDES_DONE: begin
        next_done = 1'b1;
        next_allow = 1'b0;
        next_state = BDES_IDLE;
      end
      default: begin
        next_state = BDES_IDLE;
      end
    endcase
    // A change seen in the same cycle as a clear must still reach the next command.
    if (sync_b[2] && !mchg_d) begin
      next_attn = '1;
    end
    next_busy = (next_state != BDES_IDLE);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= BDES_IDLE;
      cmd <= '0;
      found <= 1'b0;
      res <= '0;
      done <= 1'b0;
      allow <= 1'b0;
      stop_lba <= 32'h0;
      attn <= '1;
      lim_ok <= '0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      cmd <= next_cmd;
      found <= next_found;
      res <= next_res;
      done <= next_done;
      allow <= next_allow;
      stop_lba <= next_stop_lba;
      attn <= next_attn;
      lim_ok <= next_lim_ok;
      busy <= next_busy;
    end
  end

  // Limit storage per initiator has no reset; values only matter while lim_ok is set.
  always_ff @(posedge clk_sys_i) begin
    lim_lo <= next_lim_lo;
    lim_hi <= next_lim_hi;
  end

  assign result_o = res;
  assign done_o = done;
  assign busy_o = busy;
  assign xfer_allow_o = allow;
  assign xfer_stop_lba_o = stop_lba;
  assign attn_o = attn;

  property p_unlinked_rel;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state == BDES_IDLE && cmd_valid_i && cmd_i.relative && !cmd_i.linked && !attn[id])
      |=> (res.key == `BDES_KEY_ILLEGAL) ##1 done;
  endproperty
  a_unlinked_rel: assert property (p_unlinked_rel) else $error("unlinked relative accepted");

  property p_attn;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state == BDES_IDLE && cmd_valid_i && attn[id])
      |=> (res.key == `BDES_KEY_UNIT_ATTN &&
           (!attn[$past(id)] || $past(sync_b[2] && !mchg_d)));
  endproperty
  a_attn: assert property (p_attn) else $error("unit attention not reported");

  property p_wprot;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state == BDES_IDLE && cmd_valid_i && cmd_i.is_write && sync_b[0] && !attn[id] &&
       !cmd_i.relative && !cmd_i.opt_unsupported && last_blk <= {1'b0, LAST_LBA})
      |=> (res.key == `BDES_KEY_PROTECT && !allow && state == BDES_DONE);
  endproperty
  a_wprot: assert property (p_wprot) else $error("protected write allowed");

  property p_range;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state == BDES_IDLE && cmd_valid_i && cmd_i.lba > LAST_LBA && !attn[id] &&
       !(cmd_i.relative && !cmd_i.linked) && !cmd_i.opt_unsupported)
      |=> (res.key == `BDES_KEY_ILLEGAL && res.info == $past(cmd_i.lba) && res.info_valid);
  endproperty
  a_range: assert property (p_range) else $error("bad address not reported");

  property p_check;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (done && found) |-> (res.status == `BDES_STAT_CHECK && res.key != `BDES_KEY_NO_SENSE);
  endproperty
  a_check: assert property (p_check) else $error("error without check condition");

  property p_first;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state == BDES_EXEC && found) |=> $stable(res.key);
  endproperty
  a_first: assert property (p_first) else $error("first condition overwritten");

  property p_diag;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state == BDES_EXEC && fault_valid_i && !found && fault_i.diag_fail)
      |=> res.key == `BDES_KEY_HARDWARE;
  endproperty
  a_diag: assert property (p_diag) else $error("diag failure key wrong");

  property p_overrun;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state == BDES_EXEC && fault_valid_i && !found && fault_i.overrun && !fault_i.diag_fail &&
       !fault_i.unrecov_med && !fault_i.unrecov_hw) |=> (res.key == `BDES_KEY_ABORTED && !allow);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun key wrong");

  property p_done_once;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state == BDES_DONE) |=> done ##1 !done;
  endproperty
  a_done_once: assert property (p_done_once) else $error("done pulse wrong");

endmodule

// ==== hdl/bdes_pkg.sv ====
// Types for the block-device error and status checker.
package bdes_pkg;
  typedef struct packed {
    logic [2:0] init_id;
    logic is_write;
    logic is_set_limits;
    logic relative;
    logic linked;
    logic opt_unsupported;
    logic [31:0] lba;
    logic [15:0] nblocks;
    logic [31:0] lim_lo;
    logic [31:0] lim_hi;
  } bdes_cmd_t;

  typedef struct packed {
    logic diag_fail;
    logic unrecov_hw;
    logic unrecov_med;
    logic recovered;
    logic overrun;
    logic blank_hit;
    logic written_hit;
    logic [31:0] event_lba;
  } bdes_fault_t;

  typedef struct packed {
    logic [7:0] status;
    logic [3:0] key;
    logic [7:0] asc;
    logic info_valid;
    logic [31:0] info;
    logic [2:0] init_id;
  } bdes_result_t;

  typedef enum logic [2:0] {
    BDES_IDLE = 3'b001,
    BDES_EXEC = 3'b010,
    BDES_DONE = 3'b100
  } bdes_state_t;
endpackage

// ==== tb/bdes_dpath.sv ====
// Data path model: answers each granted transfer with an optional fault and an end pulse.
`timescale 1ns/100ps
module bdes_dpath
  import bdes_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Scenario control.
  input wire logic [3:0] lat_i,
  input wire logic flt_en_i,
  input wire bdes_fault_t flt_i,
  // Block side.
  input wire logic xfer_allow_i,
  output logic fault_valid_o,
  output bdes_fault_t fault_o,
  output logic xfer_end_o
);
  logic [4:0] cnt;
  logic allow_q;
  logic at_end;
  assign at_end = cnt == ({1'b0, lat_i} + 5'h02);
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 5'h00;
      allow_q <= 1'b0;
      fault_valid_o <= 1'b0;
      fault_o <= '0;
      xfer_end_o <= 1'b0;
    end else begin
      allow_q <= xfer_allow_i;
      fault_valid_o <= flt_en_i && cnt == 5'h02;
      xfer_end_o <= at_end;
      // Outside a report the fields carry the inverse, so a stale value is never read as news.
      fault_o <= (flt_en_i && cnt == 5'h02) ? flt_i : ~flt_i;
      if (xfer_allow_i && !allow_q) begin
        cnt <= 5'h01;
      end else if (at_end) begin
        cnt <= 5'h00;
      end else if (cnt != 5'h00) begin
        cnt <= cnt + 5'h01;
      end
    end
  end
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the block-device error checker.
`timescale 1ns/100ps
`include "bdes_cfg.svh"
module tb;
  import bdes_pkg::*;
  localparam logic [31:0] LAST = 32'h0000_03ff;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wprot_i = 1'b0;
  logic worm_i = 1'b0;
  logic blank_chk_i = 1'b0;
  logic medium_chg_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  bdes_cmd_t cmd_i = '0;
  logic fault_valid_i, xfer_end_i, done_o, busy_o, xfer_allow_o;
  bdes_fault_t fault_i;
  bdes_fault_t flt = '0;
  logic [3:0] lat = 4'h3;
  logic flt_en = 1'b0;
  bdes_result_t result_o;
  logic [31:0] xfer_stop_lba_o, stop_at_end;
  logic [7:0] attn_o;
  logic allow_at_end;
  int allow_cycles = 0;
  int n_errors = 0;
  int total_checks = 0;
  bdes_core #(.NUM_INIT(8), .LAST_LBA(LAST)) dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .wprot_i(wprot_i), .worm_i(worm_i), .blank_chk_i(blank_chk_i),
    .medium_chg_i(medium_chg_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .fault_valid_i(fault_valid_i), .fault_i(fault_i), .xfer_end_i(xfer_end_i),
    .result_o(result_o), .done_o(done_o), .busy_o(busy_o), .xfer_allow_o(xfer_allow_o),
    .xfer_stop_lba_o(xfer_stop_lba_o), .attn_o(attn_o));
  bdes_dpath dp (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .lat_i(lat), .flt_en_i(flt_en),
    .flt_i(flt), .xfer_allow_i(xfer_allow_o), .fault_valid_o(fault_valid_i),
    .fault_o(fault_i), .xfer_end_o(xfer_end_i));
  always #10 clk_sys_i = ~clk_sys_i;
  // Sampled mid-cycle, where every registered output has settled.
  always @(negedge clk_sys_i) begin
    if (xfer_allow_o === 1'b1) begin
      allow_cycles++;
    end
    if (xfer_end_i) begin
      stop_at_end = xfer_stop_lba_o;
      allow_at_end = xfer_allow_o;
    end
  end
  task automatic complete_run();
    if (n_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, m, got, exp);
    end
  endtask
  task automatic chk_res(input logic [3:0] k, input logic iv, input logic [31:0] inf);
    chk({24'h0, result_o.status}, {24'h0, (k == `BDES_KEY_NO_SENSE) ?
      `BDES_STAT_GOOD : `BDES_STAT_CHECK}, "status");
    chk({28'h0, result_o.key}, {28'h0, k}, "sense key");
    if (iv) begin
      chk({31'h0, result_o.info_valid}, 32'h1, "info valid");
      chk(result_o.info, inf, "info field");
    end
  endtask
  // Flags are {write, relative, linked}.
  function automatic bdes_cmd_t mk(input logic [2:0] id, input logic [2:0] f,
                                   input logic [31:0] lba, input logic [15:0] nb);
    mk = '{init_id: id, is_write: f[2], relative: f[1], linked: f[0], lba: lba,
           nblocks: nb, default: '0};
  endfunction
  task automatic run(input bdes_cmd_t c);
    int n;
    @(posedge clk_sys_i);
    #1;
    cmd_i = c;
    cmd_valid_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    cmd_valid_i = 1'b0;
    chk({31'h0, busy_o}, 32'h1, "busy after issue");
    n = 0;
    while (done_o !== 1'b1 && n < 200) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    chk({31'h0, done_o}, 32'h1, "command completion");
    chk({31'h0, busy_o}, 32'h0, "busy after completion");
    chk({29'h0, result_o.init_id}, {29'h0, c.init_id}, "result initiator");
  endtask
  task automatic settle();
    repeat (4) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic t_attention();
    for (int i = 0; i < 3; i++) begin
      run(mk(i[2:0], 3'h0, 32'h10, 16'h1));
      chk_res(`BDES_KEY_UNIT_ATTN, 1'b0, 32'h0);
      chk({24'h0, result_o.asc}, {24'h0, `BDES_ASC_RESET}, "sense code");
      chk({31'h0, attn_o[i]}, 32'h0, "attention cleared");
    end
    chk({24'h0, attn_o}, 32'hf8, "others still pending");
    run(mk(3'h0, 3'h0, 32'h10, 16'h1));
    chk_res(`BDES_KEY_NO_SENSE, 1'b0, 32'h0);
  endtask
  task automatic t_range();
    bdes_cmd_t c;
    run(mk(3'h0, 3'h0, LAST + 32'h1, 16'h1));
    chk_res(`BDES_KEY_ILLEGAL, 1'b1, LAST + 32'h1);
    chk({24'h0, result_o.asc}, {24'h0, `BDES_ASC_LBA_RANGE}, "sense code");
    run(mk(3'h0, 3'h0, LAST, 16'h2));
    chk_res(`BDES_KEY_ILLEGAL, 1'b1, LAST + 32'h1);
    c = mk(3'h0, 3'h0, 32'h20, 16'h1);
    c.opt_unsupported = 1'b1;
    run(c);
    chk_res(`BDES_KEY_ILLEGAL, 1'b0, 32'h0);
    chk({24'h0, result_o.asc}, {24'h0, `BDES_ASC_INV_FIELD}, "sense code");
    run(mk(3'h0, 3'h0, LAST, 16'h1));
    chk_res(`BDES_KEY_NO_SENSE, 1'b0, 32'h0);
  endtask
  task automatic t_protect();
    int a0;
    wprot_i = 1'b1;
    settle();
    a0 = allow_cycles;
    run(mk(3'h1, 3'h4, 32'h40, 16'h1));
    chk_res(`BDES_KEY_PROTECT, 1'b0, 32'h0);
    chk({24'h0, result_o.asc}, {24'h0, `BDES_ASC_WPROT}, "sense code");
    chk(allow_cycles, a0, "protected write moved data");
    run(mk(3'h1, 3'h0, 32'h40, 16'h1));
    chk_res(`BDES_KEY_NO_SENSE, 1'b0, 32'h0);
    wprot_i = 1'b0;
    settle();
  endtask
  task automatic t_relative();
    bdes_cmd_t c;
    run(mk(3'h0, 3'h2, 32'h100, 16'h1));
    chk_res(`BDES_KEY_ILLEGAL, 1'b0, 32'h0);
    c = mk(3'h0, 3'h1, 32'h0, 16'h1);
    c.is_set_limits = 1'b1;
    c.lim_lo = 32'h100;
    c.lim_hi = 32'h1ff;
    run(c);
    chk_res(`BDES_KEY_NO_SENSE, 1'b0, 32'h0);
    run(mk(3'h0, 3'h3, 32'h1f0, 16'h20));
    chk_res(`BDES_KEY_ILLEGAL, 1'b1, 32'h200);
    run(mk(3'h0, 3'h3, 32'h100, 16'h100));
    chk_res(`BDES_KEY_NO_SENSE, 1'b0, 32'h0);
    run(mk(3'h1, 3'h3, 32'h1f0, 16'h20));
    chk_res(`BDES_KEY_NO_SENSE, 1'b0, 32'h0);
  endtask
  task automatic t_faults();
    logic [3:0] k [5] = '{`BDES_KEY_HARDWARE, `BDES_KEY_HARDWARE, `BDES_KEY_MEDIUM,
                          `BDES_KEY_RECOVERED, `BDES_KEY_ABORTED};
    flt_en = 1'b1;
    for (int i = 0; i < 5; i++) begin
      flt = '0;
      flt[38-i] = 1'b1;
      lat = 4'(3 * i + 3);
      run(mk(3'h2, 3'h0, 32'h60, 16'h8));
      chk_res(k[i], 1'b0, 32'h0);
    end
    flt = '0;
    flt.overrun = 1'b1;
    flt.recovered = 1'b1;
    flt.diag_fail = 1'b1;
    run(mk(3'h2, 3'h0, 32'h60, 16'h8));
    settle();
    chk_res(`BDES_KEY_HARDWARE, 1'b0, 32'h0);
    flt_en = 1'b0;
  endtask
  task automatic t_worm();
    worm_i = 1'b1;
    blank_chk_i = 1'b1;
    settle();
    flt = '0;
    flt.blank_hit = 1'b1;
    flt.event_lba = 32'h35;
    flt_en = 1'b1;
    run(mk(3'h0, 3'h0, 32'h30, 16'h10));
    chk_res(`BDES_KEY_BLANK, 1'b1, 32'h35);
    chk(stop_at_end, 32'h35, "blank stop address");
    chk({31'h0, allow_at_end}, 32'h1, "data before blank");
    flt.blank_hit = 1'b0;
    flt.written_hit = 1'b1;
    flt.event_lba = 32'h52;
    run(mk(3'h0, 3'h4, 32'h50, 16'h10));
    chk_res(`BDES_KEY_BLANK, 1'b1, 32'h52);
    flt_en = 1'b0;
  endtask
  task automatic t_medium();
    medium_chg_i = 1'b1;
    settle();
    medium_chg_i = 1'b0;
    chk({24'h0, attn_o}, 32'hff, "medium change attention");
    run(mk(3'h2, 3'h0, 32'h10, 16'h1));
    chk_res(`BDES_KEY_UNIT_ATTN, 1'b0, 32'h0);
  endtask
  // The whole run needs about 250 cycles; ten thousand marks a hang.
  initial begin
    #(20 * 10000);
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge clk_sys_i);
    #1;
    rst_n_i = 1'b1;
    t_attention();
    t_range();
    t_protect();
    t_relative();
    t_faults();
    t_worm();
    t_medium();
    complete_run();
  end
endmodule
